// ==== logic/mafl_pkg.sv ====
/*
 * Constants and carrier types for the monitor alarm status flags.
 * Assumes a single 100 MHz clock and a host port that reads one cycle later.
 */
// ==========================================================
// How it works
// - Evaluate every monitored condition after each conversion.
// - Set flag after N consecutive out-of-range results.
// - In-range result before N restarts count, flag stays.
// - Latched flags hold until read, resolved or not.
// - Read clears all flags; persisting faults reassert.
// - Hardware, software, power-on resets clear all flags.
// - With hold-off set, flags follow live condition.
// - Read-only status register at 4Fh, resets 0000h.
// - Bits 15, 1, 0 read zero; writes ignored.
// - Bit 14 flags channel 0 or pair 0/1.
// - Bit 12 flags channel 2 or pair 2/3.
// - Bit 13 flags channel 1, bit 11 channel 3.
// - Bits 10, 9 on-chip low/high, only when enabled.
// - Bits 8, 7 remote A low/high when enabled.
// - Bits 6, 5 remote B low/high when enabled.
// - Bits 4, 3 remote A/B fault when enabled.
// - Bit 2 trips at 150 C, 8 C hysteresis.
// - Die flag zero while on-chip sensor disabled.
// - Masked alarms still flag but never pull alert.
package mafl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] MAFL_ADDR_STATUS = 8'h4f;
	localparam logic [15:0] MAFL_STATUS_RESET = 16'h0000;
	localparam int MAFL_ADDR_W = 8;
	localparam int MAFL_DATA_W = 16;

	// ==========================================================
	// Flag layout: condition index i lives at status bit i + 2
	localparam int MAFL_NUM_COND = 13;
	localparam int MAFL_FLAG_LSB = 2;
	localparam int MAFL_IDX_AIN0 = 12;
	localparam int MAFL_IDX_AIN1 = 11;
	localparam int MAFL_IDX_AIN2 = 10;
	localparam int MAFL_IDX_AIN3 = 9;
	localparam int MAFL_IDX_ONCHIP_UNDER = 8;
	localparam int MAFL_IDX_ONCHIP_OVER = 7;
	localparam int MAFL_IDX_REMOTE_A_UNDER = 6;
	localparam int MAFL_IDX_REMOTE_A_OVER = 5;
	localparam int MAFL_IDX_REMOTE_B_UNDER = 4;
	localparam int MAFL_IDX_REMOTE_B_OVER = 3;
	localparam int MAFL_IDX_REMOTE_A_FAULT = 2;
	localparam int MAFL_IDX_REMOTE_B_FAULT = 1;
	localparam int MAFL_IDX_DIE = 0;

	// ==========================================================
	// Consecutive-count and die temperature figures
	localparam int MAFL_CNT_W = 4;
	localparam int MAFL_TEMP_W = 12;
	localparam logic signed [11:0] MAFL_DIE_TRIP_C = 12'sh096;
	localparam logic signed [11:0] MAFL_DIE_HYST_C = 12'sh008;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [MAFL_NUM_COND-1:1] eval;
		logic [MAFL_NUM_COND-1:1] out_range;
	} mafl_result_type;

	typedef struct packed {
		logic valid;
		logic signed [MAFL_TEMP_W-1:0] celsius;
	} mafl_die_type;

	typedef struct packed {
		logic [MAFL_ADDR_W-1:0] addr;
		logic [MAFL_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} mafl_host_type;

endpackage

// ==== logic/mafl_status.sv ====
/*
 * Alarm status register of the multichannel monitor: per-condition
 * consecutive-count filters, latched or live flags, read-to-clear,
 * die over-temperature hysteresis and the masked active-low alert.
 * Assumes conversion results arrive as one-cycle strobes synchronous to
 * clk, and that the host port gives strobes of one cycle, never both.
 */
`timescale 1ns/1ns
module mafl_status (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	// Host register port
	input wire mafl_pkg::mafl_host_type host,
	output logic [mafl_pkg::MAFL_DATA_W-1:0] rdata,
	// Conversion results
	input wire mafl_pkg::mafl_result_type result,
	input wire mafl_pkg::mafl_die_type die,
	// Configuration
	input wire logic [mafl_pkg::MAFL_CNT_W-1:0] consec_count,
	input wire logic alarm_hold_off,
	input wire logic onchip_temp_enable,
	input wire logic remote_a_enable,
	input wire logic remote_b_enable,
	input wire logic [mafl_pkg::MAFL_DATA_W-1:0] alarm_enable,
	// Alert pin
	output logic alert_n
);
	import mafl_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [MAFL_NUM_COND-1:0][MAFL_CNT_W-1:0] cnt;
		logic [MAFL_NUM_COND-1:0] flags;
		logic die_hot;
		logic [MAFL_DATA_W-1:0] rdata;
	} mafl_state_type;

	localparam mafl_state_type MAFL_STATE_RESET = '{
		cnt: '0,
		flags: '0,
		die_hot: 1'b0,
		rdata: MAFL_STATUS_RESET
	};

	mafl_state_type state;
	mafl_state_type next_state;

	// ==========================================================
	// Helpers
	function automatic logic [MAFL_CNT_W-1:0] mafl_sat_inc(
		input logic [MAFL_CNT_W-1:0] value
	);
		mafl_sat_inc = (&value) ? value : value + 1'b1;
	endfunction

	// Which sensor enable gates each condition
	function automatic logic [MAFL_NUM_COND-1:0] mafl_cond_enable(
		input logic lt_en,
		input logic ra_en,
		input logic rb_en
	);
		logic [MAFL_NUM_COND-1:0] en;
		en = '1;
		en[MAFL_IDX_ONCHIP_UNDER] = lt_en;
		en[MAFL_IDX_ONCHIP_OVER] = lt_en;
		en[MAFL_IDX_DIE] = lt_en;
		en[MAFL_IDX_REMOTE_A_UNDER] = ra_en;
		en[MAFL_IDX_REMOTE_A_OVER] = ra_en;
		en[MAFL_IDX_REMOTE_A_FAULT] = ra_en;
		en[MAFL_IDX_REMOTE_B_UNDER] = rb_en;
		en[MAFL_IDX_REMOTE_B_OVER] = rb_en;
		en[MAFL_IDX_REMOTE_B_FAULT] = rb_en;
		mafl_cond_enable = en;
	endfunction

	function automatic logic [MAFL_DATA_W-1:0] mafl_pack_status(
		input logic [MAFL_NUM_COND-1:0] flags
	);
		// Reserved bits 15, 1 and 0 are hard zero
		mafl_pack_status = {1'b0, flags, 2'b00};
	endfunction

	// ==========================================================
	// Combinational decode
	logic [MAFL_NUM_COND-1:0] cond_en;
	logic [MAFL_NUM_COND-1:0] eval_all;
	logic [MAFL_NUM_COND-1:0] out_all;
	logic [MAFL_CNT_W-1:0] need;
	logic status_rd;
	logic next_die_hot;
	logic [MAFL_DATA_W-1:0] status_now;

	assign cond_en = mafl_cond_enable(onchip_temp_enable, remote_a_enable,
		remote_b_enable);
	// Zero is treated as one so a filter can never be switched off
	assign need = (consec_count == '0) ? MAFL_CNT_W'(1) : consec_count;
	assign status_rd = host.rd && (host.addr == MAFL_ADDR_STATUS);
	assign status_now = mafl_pack_status(state.flags);

	// Die comparator with hysteresis: trip at 150, release 8 below
	always_comb begin
		next_die_hot = state.die_hot;
		if (die.valid) begin
			if (die.celsius >= MAFL_DIE_TRIP_C) begin
				next_die_hot = 1'b1;
			end else if (die.celsius <=
				MAFL_DIE_TRIP_C - MAFL_DIE_HYST_C) begin
				next_die_hot = 1'b0;
			end
		end
		if (!onchip_temp_enable) begin
			next_die_hot = 1'b0;
		end
	end

	// Analog channels 0 and 2 already carry single or pair results
	assign eval_all = {result.eval, die.valid};
	assign out_all = {result.out_range, next_die_hot};

	// ==========================================================
	// Next state
	always_comb begin
		logic [MAFL_CNT_W-1:0] c;
		c = '0;
		next_state = state;
		next_state.die_hot = next_die_hot;
		// Snapshot taken before the clear below, so the host sees the flags
		next_state.rdata = status_rd ? status_now : '0;
		if (status_rd) begin
			next_state.flags = '0;
		end
		for (int i = 0; i < MAFL_NUM_COND; i++) begin
			if (!cond_en[i]) begin
				// A disabled sensor is ignored and must not keep an old flag
				next_state.cnt[i] = '0;
				next_state.flags[i] = 1'b0;
			end else if (eval_all[i]) begin
				if (out_all[i]) begin
					c = mafl_sat_inc(state.cnt[i]);
					next_state.cnt[i] = c;
					if (c >= need) begin
						// Set wins over a read clear in the same cycle
						next_state.flags[i] = 1'b1;
					end
				end else begin
					next_state.cnt[i] = '0;
					if (alarm_hold_off) begin
						next_state.flags[i] = 1'b0;
					end
				end
			end
		end
		// Latched mode: no path clears a flag except read, reset or disabling its sensor
		if (soft_reset) begin
			next_state = MAFL_STATE_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= MAFL_STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata = state.rdata;
	// Masked alarms keep their flag but stay off the pin
	assign alert_n = ~|(status_now & alarm_enable);

	// ==========================================================
	// Checks
	a_reserved_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		status_now[15] == 1'b0 && status_now[1:0] == 2'b00
	) else $error("Reserved status bits not zero");

	a_read_returns_flags: assert property (
		@(posedge clk) disable iff (!rst_n)
		(status_rd && !soft_reset) |=> rdata == $past(status_now)
	) else $error("Status read returned wrong data");

	a_other_addr_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		!status_rd |=> rdata == 16'h0000
	) else $error("Unmapped read not zero");

	a_read_clears_flag: assert property (
		@(posedge clk) disable iff (!rst_n)
		(status_rd && !(|(eval_all & out_all))) |=> state.flags == '0
	) else $error("Read did not clear flags");

	a_soft_reset_clears: assert property (
		@(posedge clk) disable iff (!rst_n)
		soft_reset |=> state.flags == '0 && state.cnt == '0
	) else $error("Software reset left flags");

	a_in_range_restart: assert property (
		@(posedge clk) disable iff (!rst_n)
		(eval_all[MAFL_IDX_AIN0] && !out_all[MAFL_IDX_AIN0] && !soft_reset)
		|=> state.cnt[MAFL_IDX_AIN0] == '0
	) else $error("Count not restarted after in-range");

	a_no_early_flag: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!state.flags[MAFL_IDX_AIN1] && eval_all[MAFL_IDX_AIN1]
		&& mafl_sat_inc(state.cnt[MAFL_IDX_AIN1]) < need)
		|=> !state.flags[MAFL_IDX_AIN1]
	) else $error("Flag set before N results");

	a_flag_at_count: assert property (
		@(posedge clk) disable iff (!rst_n)
		(eval_all[MAFL_IDX_AIN2] && out_all[MAFL_IDX_AIN2] && !soft_reset
		&& mafl_sat_inc(state.cnt[MAFL_IDX_AIN2]) >= need)
		|=> state.flags[MAFL_IDX_AIN2]
	) else $error("Flag not set at N results");

	a_latch_holds: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!alarm_hold_off && state.flags[MAFL_IDX_AIN3] && !status_rd
		&& !soft_reset && cond_en[MAFL_IDX_AIN3])
		|=> state.flags[MAFL_IDX_AIN3]
	) else $error("Latched flag dropped without read");

	a_live_follow: assert property (
		@(posedge clk) disable iff (!rst_n)
		(alarm_hold_off && eval_all[MAFL_IDX_REMOTE_A_OVER]
		&& !out_all[MAFL_IDX_REMOTE_A_OVER])
		|=> !state.flags[MAFL_IDX_REMOTE_A_OVER]
	) else $error("Live flag did not follow condition");

	a_die_disabled: assert property (
		@(posedge clk) disable iff (!rst_n)
		!onchip_temp_enable |=> !status_now[MAFL_FLAG_LSB + MAFL_IDX_DIE]
	) else $error("Die flag set while sensor off");

	a_die_hysteresis: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state.die_hot && onchip_temp_enable && die.valid && !soft_reset
		&& die.celsius > 12'sh08e) |=> state.die_hot
	) else $error("Die alarm released inside hysteresis");

	a_remote_gate: assert property (
		@(posedge clk) disable iff (!rst_n)
		!remote_b_enable |=> !state.flags[MAFL_IDX_REMOTE_B_FAULT]
		&& state.cnt[MAFL_IDX_REMOTE_B_FAULT] == '0
	) else $error("Remote B fault flagged while disabled");

	a_masked_alert: assert property (
		@(posedge clk) disable iff (!rst_n)
		(alarm_enable == 16'h0000) |-> alert_n
	) else $error("Masked alarm pulled alert low");

	// Async reset holds everything clear, with no disable so it is seen
	a_hw_reset_clear: assert property (
		@(posedge clk)
		!rst_n |-> state.flags == '0 && rdata == '0 && alert_n
	) else $error("Hardware reset left flags or data");

	a_soft_rdata_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		soft_reset |=> rdata == '0
	) else $error("Software reset left read data");

	a_rdata_reserved: assert property (
		@(posedge clk) disable iff (!rst_n)
		rdata[15] == 1'b0 && rdata[1:0] == 2'b00
	) else $error("Reserved read data bits not zero");

	a_write_ignored: assert property (
		@(posedge clk) disable iff (!rst_n)
		(host.wr && !status_rd && !soft_reset && eval_all == '0
		&& cond_en == '1) |=> $stable(state.flags)
	) else $error("Write changed status flags");

	a_die_trip: assert property (
		@(posedge clk) disable iff (!rst_n)
		(onchip_temp_enable && die.valid && !soft_reset
		&& die.celsius >= MAFL_DIE_TRIP_C) |=> state.die_hot
	) else $error("Die alarm did not trip");

	a_die_release: assert property (
		@(posedge clk) disable iff (!rst_n)
		(die.valid && die.celsius <= MAFL_DIE_TRIP_C - MAFL_DIE_HYST_C)
		|=> !state.die_hot
	) else $error("Die alarm not released below hysteresis");

	a_onchip_gate: assert property (
		@(posedge clk) disable iff (!rst_n)
		!onchip_temp_enable |=> !state.flags[MAFL_IDX_ONCHIP_UNDER]
		&& !state.flags[MAFL_IDX_ONCHIP_OVER]
	) else $error("On-chip flag set while disabled");

	a_remote_a_gate: assert property (
		@(posedge clk) disable iff (!rst_n)
		!remote_a_enable |=> !state.flags[MAFL_IDX_REMOTE_A_UNDER]
		&& !state.flags[MAFL_IDX_REMOTE_A_OVER]
		&& !state.flags[MAFL_IDX_REMOTE_A_FAULT]
	) else $error("Remote A flag set while disabled");

	a_remote_b_range: assert property (
		@(posedge clk) disable iff (!rst_n)
		!remote_b_enable |=> !state.flags[MAFL_IDX_REMOTE_B_UNDER]
		&& !state.flags[MAFL_IDX_REMOTE_B_OVER]
	) else $error("Remote B range flag set while disabled");

	a_alert_enabled: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state.flags[MAFL_IDX_AIN0]
		&& alarm_enable[MAFL_FLAG_LSB + MAFL_IDX_AIN0]) |-> !alert_n
	) else $error("Enabled alarm did not pull alert low");

	a_count_step: assert property (
		@(posedge clk) disable iff (!rst_n)
		(eval_all[MAFL_IDX_AIN2] && out_all[MAFL_IDX_AIN2] && !soft_reset
		&& state.cnt[MAFL_IDX_AIN2] != '1)
		|=> state.cnt[MAFL_IDX_AIN2] == $past(state.cnt[MAFL_IDX_AIN2]) + 1'b1
	) else $error("Count did not step on out-of-range result");

	a_count_idle: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!eval_all[MAFL_IDX_AIN1] && !soft_reset)
		|=> $stable(state.cnt[MAFL_IDX_AIN1])
	) else $error("Count moved without a result");

	a_live_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		(alarm_hold_off && !eval_all[MAFL_IDX_AIN0] && !status_rd
		&& !soft_reset) |=> $stable(state.flags[MAFL_IDX_AIN0])
	) else $error("Live flag changed without a result");

	a_latch_in_range: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!alarm_hold_off && state.flags[MAFL_IDX_AIN0]
		&& eval_all[MAFL_IDX_AIN0] && !out_all[MAFL_IDX_AIN0]
		&& !status_rd && !soft_reset) |=> state.flags[MAFL_IDX_AIN0]
	) else $error("Latched flag cleared by in-range result");

endmodule // mafl_status

// ==== tb/tb_mafl_status.sv ====
/*
 * Self-checking bench of the alarm status flags: host reads and writes,
 * conversion strobes, die samples and both resets driven directly.
 * Assumes mafl_pkg is compiled first and reads answer one cycle later.
 */
`timescale 1ns/1ns
module tb_mafl_status;
	import mafl_pkg::*;

	// ==========================================================
	// Signals
	logic clk;
	logic rst_n;
	logic soft_reset;
	logic alarm_hold_off;
	logic onchip_temp_enable;
	logic remote_a_enable;
	logic remote_b_enable;
	logic alert_n;
	logic [MAFL_CNT_W-1:0] consec_count;
	logic [MAFL_DATA_W-1:0] alarm_enable;
	logic [MAFL_DATA_W-1:0] rdata;
	mafl_host_type host;
	mafl_result_type result;
	mafl_die_type die;
	int error_cnt;
	int comparisons;
	int cycles;

	mafl_status uut (
		.clk(clk),
		.rst_n(rst_n),
		.soft_reset(soft_reset),
		.host(host),
		.rdata(rdata),
		.result(result),
		.die(die),
		.consec_count(consec_count),
		.alarm_hold_off(alarm_hold_off),
		.onchip_temp_enable(onchip_temp_enable),
		.remote_a_enable(remote_a_enable),
		.remote_b_enable(remote_b_enable),
		.alarm_enable(alarm_enable),
		.alert_n(alert_n)
	);

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			$display("MISMATCH %0t run did not finish", $time);
			test_done();
		end
	end

	// ==========================================================
	// Compare, access and stimulus tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t rdata %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_alert(input logic exp);
		comparisons++;
		if (alert_n !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t alert_n %b expected %b", $time, alert_n, exp);
		end
	endtask

	task automatic rd(input logic [15:0] exp);
		@(posedge clk);
		host.rd <= 1'b1;
		host.addr <= MAFL_ADDR_STATUS;
		@(posedge clk);
		host.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	task automatic wr(input logic [15:0] data);
		@(posedge clk);
		host.wr <= 1'b1;
		host.addr <= MAFL_ADDR_STATUS;
		host.wdata <= data;
		@(posedge clk);
		host.wr <= 1'b0;
	endtask

	// Gap cycle between strobes keeps each eval a clean one-cycle pulse
	task automatic ev(input int idx, input logic out, input int n);
		repeat (n) begin
			@(posedge clk);
			result.eval[idx] <= 1'b1;
			result.out_range[idx] <= out;
			@(posedge clk);
			result.eval <= '0;
		end
		#1;
	endtask

	task automatic dt(input logic signed [11:0] c, input int n);
		repeat (n) begin
			@(posedge clk);
			die.valid <= 1'b1;
			die.celsius <= c;
			@(posedge clk);
			die.valid <= 1'b0;
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		soft_reset = 1'b0;
		host = '0;
		result = '0;
		die = '0;
		consec_count = 4'h2;
		alarm_hold_off = 1'b0;
		onchip_temp_enable = 1'b1;
		remote_a_enable = 1'b1;
		remote_b_enable = 1'b1;
		alarm_enable = 16'hffff;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'h0000);
		wr(16'hffff);
		rd(16'h0000);
		ev(12, 1, 1);
		ev(12, 0, 1);
		ev(12, 1, 1);
		rd(16'h0000);
		ev(12, 1, 1);
		chk_alert(1'b0);
		ev(12, 0, 1);
		rd(16'h4000);
		rd(16'h0000);
		for (int i = 1; i < MAFL_NUM_COND; i++) begin
			ev(i, 1, 2);
			rd(16'h0001 << (i + 2));
			ev(i, 0, 1);
		end
		ev(11, 1, 2);
		rd(16'h2000);
		ev(11, 1, 1);
		rd(16'h2000);
		ev(11, 0, 1);
		rd(16'h0000);
		consec_count <= 4'h1;
		ev(11, 1, 1);
		rd(16'h2000);
		ev(11, 0, 1);
		consec_count <= 4'h2;
		alarm_enable <= 16'h0000;
		ev(10, 1, 2);
		chk_alert(1'b1);
		rd(16'h1000);
		ev(10, 0, 1);
		alarm_enable <= 16'hffff;
		alarm_hold_off <= 1'b1;
		ev(9, 1, 2);
		chk_alert(1'b0);
		ev(9, 0, 1);
		chk_alert(1'b1);
		rd(16'h0000);
		alarm_hold_off <= 1'b0;
		onchip_temp_enable <= 1'b0;
		remote_a_enable <= 1'b0;
		ev(8, 1, 2);
		ev(2, 1, 2);
		dt(12'sd160, 2);
		rd(16'h0000);
		onchip_temp_enable <= 1'b1;
		remote_a_enable <= 1'b1;
		dt(12'sd150, 2);
		rd(16'h0004);
		dt(12'sd143, 1);
		rd(16'h0004);
		dt(12'sd142, 1);
		rd(16'h0000);
		dt(12'sd149, 2);
		rd(16'h0000);
		ev(9, 1, 2);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		rd(16'h0000);
		ev(9, 1, 2);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(16'h0000);
		test_done();
	end

endmodule // tb_mafl_status
